//--- hw/pew_defs.vh
// timing counts, geometry and command defaults for the page-write host
// assumes a 20 mhz system clock (50 ns period)
`ifndef PEW_DEFS_VH
`define PEW_DEFS_VH
// ==========================================================
// geometry
`define PEW_ADDR_W 13
`define PEW_PAGE_LSB 6
`define PEW_BYTE_W 6
`define PEW_PAGE_BYTES 64
// ==========================================================
// timing, figures in ns / us
`define PEW_CLK_NS 50
`define PEW_STROBE_NS 100
`define PEW_STROBE_CYC ((`PEW_STROBE_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_READ_NS 250
`define PEW_READ_CYC ((`PEW_READ_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_WINDOW_US 100
`define PEW_GAP_CYC ((`PEW_WINDOW_US * 1000) / `PEW_CLK_NS / 2)
`define PEW_PROG_US 10000
`define PEW_PROG_CYC ((`PEW_PROG_US * 1000) / `PEW_CLK_NS)
// ==========================================================
// operation codes on cmd_op
`define PEW_OP_READ 2'h0
`define PEW_OP_WRITE 2'h1
`define PEW_OP_LOCK 2'h2
`endif

//--- hw/pew_sync2.v
// two-flip-flop synchroniser for inputs from the device pins
// assumes one clock; first stage read only by the second
`timescale 1ns/10ps
module pew_sync2 #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- hw/pew_host.v
// host sequencer driving an 8k x 8 parallel page-write eeprom
// assumes device pins wired directly; data bus resolved outside
// Function
// - host keeps page bits constant across one program cycle of data writes.
// - write strobe controls the load; address taken on last fall.
// - loading continues while each load starts inside the window.
// - host holds output gate high through every byte load.
// - chip erase needs high voltage on output gate with a write.
// - three-byte sequence enables write lock; host may stop.
`timescale 1ns/10ps
`include "pew_defs.vh"
module pew_host #(
  parameter PROG_CYC = `PEW_PROG_CYC,
  parameter [12:0] LOCK_A0 = 13'h1555,
  parameter [12:0] LOCK_A1 = 13'h0aaa,
  parameter [12:0] LOCK_A2 = 13'h1555,
  parameter [7:0] LOCK_D0 = 8'haa,
  parameter [7:0] LOCK_D1 = 8'h55,
  parameter [7:0] LOCK_D2 = 8'ha0
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  // user command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [12:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire cmd_last,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg busy,
  // device pins
  output reg chip_select_n,
  output reg output_gate_n,
  output reg write_strobe_n,
  output reg [12:0] address_lines,
  input wire [7:0] data_lines_in,
  output reg [7:0] data_lines_out,
  output reg data_lines_oe
);
  localparam ST_IDLE = 7'h01;
  localparam ST_RSET = 7'h02;
  localparam ST_RSMP = 7'h04;
  localparam ST_WLOW = 7'h08;
  localparam ST_WHI = 7'h10;
  localparam ST_WAIT = 7'h20;
  localparam ST_POLL = 7'h40;

  wire [7:0] data_sync;
  reg [6:0] state;
  reg [23:0] cnt;
  reg [1:0] lock_idx;
  reg lock_run;
  reg [12:0] last_addr;
  reg page_valid;
  reg [7:0] last_data;
  reg more;

  // ==========================================================
  // pin synchroniser
  pew_sync2 #(.WIDTH(8)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .async_in(data_lines_in),
    .sync_out(data_sync)
  );

  // ==========================================================
  // lock sequence table
  reg [12:0] lock_addr;
  reg [7:0] lock_data;
  always @* begin
    case (lock_idx)
      2'h0: begin
        lock_addr = LOCK_A0;
        lock_data = LOCK_D0;
      end
      2'h1: begin
        lock_addr = LOCK_A1;
        lock_data = LOCK_D1;
      end
      default: begin
        lock_addr = LOCK_A2;
        lock_data = LOCK_D2;
      end
    endcase
  end

  // a write to another page while loading must wait for programming
  wire [6:0] cmd_page = cmd_addr[12:`PEW_PAGE_LSB];
  // re-poll start point, cut to the counter width on purpose
  wire [31:0] repoll_cnt = PROG_CYC - 16;
  reg [6:0] held_page;

  // ==========================================================
  // sequencer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 24'h000000;
      lock_idx <= 2'h0;
      lock_run <= 1'b0;
      last_addr <= 13'h0000;
      held_page <= 7'h00;
      page_valid <= 1'b0;
      last_data <= 8'h00;
      more <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      busy <= 1'b0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      address_lines <= 13'h0000;
      data_lines_out <= 8'h00;
      data_lines_oe <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          // standby between operations
          chip_select_n <= 1'b1;
          output_gate_n <= 1'b1;
          data_lines_oe <= 1'b0;
          if (lock_run) begin
            address_lines <= lock_addr;
            data_lines_out <= lock_data;
            state <= ST_WLOW;
          end else if (cmd_valid && !cmd_ready) begin
            if (cmd_op == `PEW_OP_LOCK) begin
              cmd_ready <= 1'b1;
              lock_run <= 1'b1;
              lock_idx <= 2'h0;
              busy <= 1'b1;
            end else if (cmd_op == `PEW_OP_WRITE) begin
              if (page_valid && cmd_page != held_page) begin
                cnt <= 24'h000000;
                state <= ST_WAIT;
              end else begin
                cmd_ready <= 1'b1;
                address_lines <= cmd_addr;
                data_lines_out <= cmd_data;
                more <= !cmd_last;
                held_page <= cmd_page;
                page_valid <= 1'b1;
                busy <= 1'b1;
                state <= ST_WLOW;
              end
            end else begin
              cmd_ready <= 1'b1;
              address_lines <= cmd_addr;
              chip_select_n <= 1'b0;
              output_gate_n <= 1'b0;
              cnt <= 24'h000000;
              state <= ST_RSET;
            end
          end
        end
        ST_RSET: begin
          cnt <= cnt + 24'h000001;
          if (cnt == `PEW_READ_CYC + 1)
            state <= ST_RSMP;
        end
        ST_RSMP: begin
          // two sync stages already covered by the wait above
          rsp_data <= data_sync;
          rsp_valid <= 1'b1;
          output_gate_n <= 1'b1;
          chip_select_n <= 1'b1;
          cnt <= 24'h000000;
          state <= ST_IDLE;
        end
        ST_WLOW: begin
          // gate high before the strobe falls, chip select first
          // gate only at logic level, so a load never becomes an erase
          output_gate_n <= 1'b1;
          chip_select_n <= 1'b0;
          data_lines_oe <= 1'b1;
          if (!chip_select_n) begin
            write_strobe_n <= 1'b0;
            cnt <= 24'h000000;
            state <= ST_WHI;
          end
        end
        ST_WHI: begin
          cnt <= cnt + 24'h000001;
          if (cnt == `PEW_STROBE_CYC - 1) begin
            write_strobe_n <= 1'b1;
            last_addr <= address_lines;
            last_data <= data_lines_out;
            if (lock_run) begin
              lock_idx <= lock_idx + 2'h1;
              if (lock_idx == 2'h2) begin
                lock_run <= 1'b0;
                more <= 1'b0;
              end
            end
            cnt <= 24'h000000;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // release bus; either next load inside window or programming
          chip_select_n <= 1'b1;
          data_lines_oe <= 1'b0;
          cnt <= cnt + 24'h000001;
          if (lock_run) begin
            state <= ST_IDLE;
          end else if (more && cnt < `PEW_GAP_CYC) begin
            if (cmd_valid && cmd_op == `PEW_OP_WRITE &&
                cmd_page == held_page)
              state <= ST_IDLE;
          end else if (cnt >= PROG_CYC) begin
            // worst-case program time passed; confirm by polling
            cnt <= 24'h000000;
            chip_select_n <= 1'b0;
            output_gate_n <= 1'b0;
            state <= ST_POLL;
          end
        end
        ST_POLL: begin
          address_lines <= last_addr;
          cnt <= cnt + 24'h000001;
          if (cnt == `PEW_READ_CYC + 1) begin
            output_gate_n <= 1'b1;
            chip_select_n <= 1'b1;
            cnt <= 24'h000000;
            if (data_sync[7] == last_data[7]) begin
              busy <= 1'b0;
              page_valid <= 1'b0;
              state <= ST_IDLE;
            end else begin
              cnt <= repoll_cnt[23:0];
              state <= ST_WAIT;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- test/pew_dev_model.sv
// behavioural page-write eeprom seen at the host's device pins
// assumes pins wired straight to the host; bus merged in tb
`timescale 1ns/10ps
module pew_dev_model #(
  parameter WIN = 100000,
  parameter PROG = 20000,
  parameter [62:0] LSEQ = {13'h1555, 8'haa, 13'h0aaa, 8'h55,
    13'h1555, 8'ha0}
) (
  // device pins
  input wire chip_select_n,
  input wire output_gate_n,
  input wire write_strobe_n,
  input wire [12:0] address_lines,
  input wire [7:0] data_in,
  output wire [7:0] data_out
);
  reg [7:0] mem [0:8191];
  reg [7:0] pbuf [0:63];
  reg [63:0] flg = 0;
  reg [12:0] la = 0;
  reg [7:0] ld = 0;
  reg [7:0] lq = 0;
  reg busy = 0;
  reg prog = 0;
  reg lock = 0;
  integer i;
  integer k = 0;
  time t0 = 0;
  wire rd = !chip_select_n && !output_gate_n &&
    write_strobe_n;
  wire ok = !chip_select_n && output_gate_n &&
    !prog;
  wire [7:0] poll_q = {~ld[7], ld[6:0]};
  // released pins show the inverse of the last driven byte
  assign data_out = !rd ? ~lq :
    busy ? poll_q : mem[address_lines];
  always @(data_out) if (rd) lq = data_out;
  initial for (i = 0; i < 8192; i = i + 1) mem[i] = 8'hff;
  always @(negedge write_strobe_n) if (ok) begin
    la = address_lines;
    t0 = $time;
    busy = 1;
  end
  always @(posedge write_strobe_n) if (ok && busy) begin
    pbuf[la[5:0]] = data_in;
    flg[la[5:0]] = 1;
    ld = data_in;
    k = (k < 3 && {la, data_in} == LSEQ[62-21*k -: 21]) ? k + 1 : 0;
  end
  always begin
    #500;
    if (busy && $time - t0 >= WIN) begin
      prog = 1;
      #PROG;
      for (i = 0; i < 64; i = i + 1)
        if (flg[i] && !lock && k != 3)
          mem[{la[12:6], i[5:0]}] = pbuf[i];
      if (k == 3) lock = 1;
      flg = 0;
      k = 0;
      busy = 0;
      prog = 0;
    end
  end
endmodule

//--- test/pew_host_checker.sv
// pin-level protocol checks on the page-write host
// assumes bind to pew_host; one clock domain
`timescale 1ns/10ps
module pew_host_checker (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // command side
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire cmd_ready,
  input wire busy,
  // device pins
  input wire chip_select_n,
  input wire output_gate_n,
  input wire write_strobe_n,
  input wire [12:0] address_lines,
  input wire [7:0] data_lines_out,
  input wire data_lines_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_strobe_sel: assert property (
    !write_strobe_n |-> !chip_select_n)
    else $error("strobe low without select");
  a_sel_first: assert property (
    $fell(write_strobe_n) |-> $past(!chip_select_n))
    else $error("select not set before strobe");
  a_gate_load: assert property (
    !write_strobe_n |-> output_gate_n)
    else $error("gate low during load");
  a_read_gate: assert property (
    !output_gate_n |-> write_strobe_n)
    else $error("strobe low while gate low");
  a_data_held: assert property (
    $rose(write_strobe_n) |-> data_lines_oe &&
    $stable(data_lines_out) && $stable(address_lines))
    else $error("load data moved at strobe end");
  a_no_fight: assert property (
    !output_gate_n |-> !data_lines_oe)
    else $error("host drives while device reads");
  a_strobe_len: assert property (
    $fell(write_strobe_n) |=> !write_strobe_n ##[1:4] write_strobe_n)
    else $error("strobe width wrong");
  a_busy_set: assert property (
    cmd_valid && cmd_ready && cmd_op != 2'h0 |-> ##[0:3] busy)
    else $error("busy not raised by write");
  a_busy_load: assert property (
    !write_strobe_n |-> busy)
    else $error("load outside busy");
endmodule

//--- test/tb.sv
// self-checking bench: host against the eeprom model
// assumes 20 mhz clock and shortened host program wait
`timescale 1ns/10ps
module tb;
  reg sys_clk = 0;
  reg rstn = 0;
  reg clk_en = 1;
  reg cmd_valid = 0;
  reg cmd_last = 0;
  reg [1:0] cmd_op = 0;
  reg [12:0] cmd_addr = 0;
  reg [7:0] cmd_data = 0;
  wire cmd_ready, rsp_valid, busy, chip_select_n, output_gate_n;
  wire write_strobe_n, data_lines_oe;
  wire [7:0] rsp_data, data_lines_out, dev_q;
  wire [12:0] address_lines;
  wire [7:0] data_lines_in = data_lines_oe ? data_lines_out : dev_q;
  integer n_errors = 0;
  integer comparisons = 0;
  integer n;
  pew_host #(.PROG_CYC(50)) DUT (.sys_clk, .rstn, .clk_en, .cmd_valid,
    .cmd_op, .cmd_addr, .cmd_data, .cmd_last, .cmd_ready, .rsp_valid,
    .rsp_data, .busy, .chip_select_n, .output_gate_n, .write_strobe_n,
    .address_lines, .data_lines_in, .data_lines_out, .data_lines_oe);
  pew_dev_model u_dev (.chip_select_n, .output_gate_n, .write_strobe_n,
    .address_lines, .data_in(data_lines_out), .data_out(dev_q));
  initial forever #25 sys_clk = ~sys_clk;
  task summarize;
    begin
      $display("checks %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task wt(input integer s, input integer lim);
    begin
      n = 0;
      while ((s == 0 ? cmd_ready : s == 1 ? rsp_valid : !busy) !== 1'b1
        && n <= lim) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      if (n > lim) begin
        $display("BAD wait %0d exp 1 got 0", s);
        n_errors = n_errors + 1;
        summarize;
      end
    end
  endtask
  task cmd(input [1:0] op, input [12:0] a, input [7:0] d, input l);
    begin
      @(posedge sys_clk);
      cmd_valid <= 1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_last <= l;
      wt(0, 99);
      @(posedge sys_clk);
      cmd_valid <= 0;
    end
  endtask
  task rd(input [12:0] a, input [7:0] e);
    begin
      cmd(2'h0, a, 8'h00, 1'b0);
      wt(1, 99);
      comparisons = comparisons + 1;
      if (rsp_data !== e) begin
        n_errors = n_errors + 1;
        $display("BAD read %h exp %h got %h", a, e, rsp_data);
      end
    end
  endtask
  // out of order loads, a repeat and an unloaded neighbour
  task t_page;
    begin
      cmd(2'h1, 13'h00c5, 8'ha5, 1'b0);
      cmd(2'h1, 13'h00c0, 8'h11, 1'b0);
      cmd(2'h1, 13'h00c5, 8'h3c, 1'b1);
      wt(2, 4000);
      rd(13'h00c5, 8'h3c);
      rd(13'h00c0, 8'h11);
      rd(13'h00c1, 8'hff);
      rd(13'h0105, 8'hff);
      $display("page test done");
    end
  endtask
  // frozen enable: a pending read is neither taken nor started
  task t_freeze;
    begin
      @(posedge sys_clk);
      clk_en <= 0;
      cmd_valid <= 1;
      cmd_op <= 2'h0;
      cmd_addr <= 13'h00c0;
      repeat (8) @(posedge sys_clk);
      #1;
      comparisons = comparisons + 1;
      if ({cmd_ready, chip_select_n} !== 2'b01) begin
        n_errors = n_errors + 1;
        $display("BAD freeze exp 01 got %b%b", cmd_ready, chip_select_n);
      end
      @(posedge sys_clk);
      clk_en <= 1;
      wt(0, 99);
      @(posedge sys_clk);
      cmd_valid <= 0;
      wt(1, 99);
      comparisons = comparisons + 1;
      if (rsp_data !== 8'h11) begin
        n_errors = n_errors + 1;
        $display("BAD frozen read exp 11 got %h", rsp_data);
      end
      $display("freeze test done");
    end
  endtask
  // lock sequence, then an ordinary write must not land
  task t_lock;
    begin
      cmd(2'h2, 13'h0000, 8'h00, 1'b0);
      wt(2, 6000);
      cmd(2'h1, 13'h0100, 8'h9c, 1'b1);
      wt(2, 4000);
      rd(13'h0100, 8'hff);
      $display("lock test done");
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1;
    t_page;
    t_freeze;
    t_lock;
    summarize;
  end
endmodule
bind pew_host pew_host_checker u_chk (.sys_clk, .rstn, .cmd_valid,
  .cmd_op, .cmd_ready, .busy, .chip_select_n, .output_gate_n,
  .write_strobe_n, .address_lines, .data_lines_out, .data_lines_oe);
